/* rtl/ulc_pkg.sv */
package ulc_pkg;
   // ***************************************************
   // line format control register layout
   // ***************************************************
   localparam int        CTRL_W      = 8;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int        BIT_NOPAR   = 0;
   localparam int        BIT_EVEN    = 1;
   localparam int        BIT_STOP    = 2;
   localparam int        BIT_WLS_LO  = 3;
   localparam int        BIT_WLS_HI  = 4;
   localparam int        BIT_IRQEN   = 5;
   localparam int        BIT_BRK     = 6;
   localparam int        BIT_TXREQ   = 7;

   // ***************************************************
   // status register layout
   // ***************************************************
   localparam int        ST_RXRDY    = 0;
   localparam int        ST_OE       = 1;
   localparam int        ST_PARERR   = 2;
   localparam int        ST_FE       = 3;
   localparam int        ST_LEVEL    = 4;
   localparam int        ST_EDGE     = 5;
   localparam int        ST_SHEMPTY  = 6;
   localparam int        ST_HEMPTY   = 7;
   localparam logic [7:0] BUS_IDLE   = 8'h00;

   // ***************************************************
   // word format encodings
   // ***************************************************
   localparam logic [3:0] DATA_BITS_MIN = 4'h5;
   localparam logic [2:0] STOP_HALF_1   = 3'h2;
   localparam logic [2:0] STOP_HALF_1P5 = 3'h3;
   localparam logic [2:0] STOP_HALF_2   = 3'h4;

   typedef logic [CTRL_W-1:0] ulc_byte_type;

   // data bits per word from the two length select bits
   function automatic logic [3:0] ulcDataBits(input logic [1:0] wls);
      ulcDataBits = DATA_BITS_MIN + {2'h0, wls};
   endfunction

   // stop length in half bit times
   function automatic logic [2:0] ulcStopHalves(input logic [1:0] wls, input logic stopSel);
      if (!stopSel)
         ulcStopHalves = STOP_HALF_1;
      else if (wls == 2'h0)
         ulcStopHalves = STOP_HALF_1P5;
      else
         ulcStopHalves = STOP_HALF_2;
   endfunction
endpackage

/* rtl/ulc_ctrl_if.sv */
interface ulc_ctrl_if;
   ulc_pkg::ulc_byte_type ctrl;
   logic                  reqRise;
   modport owner (output ctrl, output reqRise);
   modport user  (input ctrl, input reqRise);
endinterface

/* rtl/ulc_ctrl_reg.sv */
module ulc_ctrl_reg
(
   input  wire logic                  clk,
   input  wire logic                  reset,
   input  wire logic                  clearN,
   input  wire logic                  writeCtrl,
   input  wire ulc_pkg::ulc_byte_type txBus,
   ulc_ctrl_if.owner                  ctrlIf
);
   import ulc_pkg::*;

   ulc_byte_type ctrl_ff;
   logic         reqRise_ff;

   // ***************************************************
   // control register
   // ***************************************************
   // clear resets format
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         ctrl_ff <= CTRL_RESET;
      else if (!clearN)
         ctrl_ff <= CTRL_RESET;
      else if (writeCtrl && txBus[BIT_TXREQ])
         ctrl_ff[BIT_TXREQ] <= 1'b1;
      else if (writeCtrl)
         ctrl_ff <= txBus;
   end

   // one pulse when the request bit goes from low to high
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         reqRise_ff <= 1'b0;
      else
         reqRise_ff <= clearN && writeCtrl && txBus[BIT_TXREQ] && !ctrl_ff[BIT_TXREQ];
   end

   assign ctrlIf.ctrl    = ctrl_ff;
   assign ctrlIf.reqRise = reqRise_ff;

   property p_keepFormat;
      @(posedge clk) disable iff (reset)
      clearN && writeCtrl && txBus[BIT_TXREQ]
         |=> ctrl_ff[BIT_BRK:BIT_NOPAR] == $past(ctrl_ff[BIT_BRK:BIT_NOPAR]);
   endproperty
   a_keepFormat: assert property (p_keepFormat) else $error("format changed by request write");

   property p_clearCtrl;
      @(posedge clk) disable iff (reset)
      !clearN |=> ctrl_ff == CTRL_RESET && !reqRise_ff;
   endproperty
   a_clearCtrl: assert property (p_clearCtrl) else $error("clear did not reset control");
endmodule

/* rtl/ulc_line_ctrl.sv */
// Behaviour
// - request bit high drives the request-to-send output low.
// - setting the request bit raises the initial holding-empty interrupt.
// - a write with request bit high leaves other control bits unchanged.
// - external status input level is latched into a readable status bit.
// - falling edge on peripheral status input sets status bit and interrupts.
// - parity inhibit disables parity and holds parity error status low.
// - with parity inhibited stop bits follow data; even select ignored.
// - even parity select chooses even when high, odd when low.
// - length bits pick 5 to 8 data bits; stop select picks stop length.
// - interrupt enable gates all interrupt sources onto the output.
// - break bit forces the serial output low.
// - after break clears, output stays low until clear, CTS high or word sent.
// - control write needs strobe, chip select, register select high, write.
// - clear resets control and status and sets serial output high.
// - peripheral status bit is status bit 5 and pulls interrupt low.
module ulc_line_ctrl
(
   input  wire logic                  clk,
   input  wire logic                  reset,
   input  wire logic                  clearN,
   input  wire logic                  chipSelect,
   input  wire logic                  registerSelect,
   input  wire logic                  readNotWrite,
   input  wire logic                  busWriteStrobe,
   input  wire ulc_pkg::ulc_byte_type txBus,
   output logic [ulc_pkg::CTRL_W-1:0] rxBus,
   output logic                       rxBusOe,
   input  wire logic                  ctsN,
   input  wire logic                  extLevelStatusN,
   input  wire logic                  periphEdgeStatusIrq,
   input  wire logic                  txHoldingEmpty,
   input  wire logic                  txShiftEmpty,
   input  wire logic                  txWordDone,
   input  wire logic                  txSerialData,
   input  wire logic                  rxDataAvailable,
   input  wire logic                  rxOverrun,
   input  wire logic                  rxParityError,
   input  wire logic                  rxFramingError,
   output logic                       rtsN,
   output logic                       serialOut,
   output logic                       intN,
   output logic                       parityEnable,
   output logic                       evenParity,
   output logic [3:0]                 dataBits,
   output logic [2:0]                 stopHalves
);
   import ulc_pkg::*;

   ulc_ctrl_if   ctrlBus ();
   ulc_byte_type ctrl;
   ulc_byte_type statusWord;
   logic         strobeLast_ff;
   logic         writeStart;
   logic         writeCtrl;
   logic         writeHolding;
   logic         readStatusStart;
   logic         edgeLast_ff;
   logic         ctsLast_ff;
   logic         holdLast_ff;
   logic         edgeFlag_ff;
   logic         ctsFlag_ff;
   logic         levelFlag_ff;
   logic         holdFlag_ff;
   logic         breakHold_ff;
   logic         irqPending;
   ulc_byte_type rxBus_ff;
   logic         rxBusOe_ff;
   logic         rtsN_ff;
   logic         serialOut_ff;
   logic         intN_ff;
   logic         parityEnable_ff;
   logic         evenParity_ff;
   logic [3:0]   dataBits_ff;
   logic [2:0]   stopHalves_ff;

   // ***************************************************
   // bus decode
   // ***************************************************
   // act once, on the first cycle of the strobe, so a long strobe
   // cannot see its own request bit and mistake a second rise
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         strobeLast_ff <= 1'b0;
      else
         strobeLast_ff <= busWriteStrobe;
   end

   assign writeStart      = busWriteStrobe && !strobeLast_ff && chipSelect;
   assign writeCtrl       = writeStart && registerSelect && !readNotWrite;
   assign writeHolding    = writeStart && !registerSelect && !readNotWrite;
   assign readStatusStart = writeStart && registerSelect && readNotWrite;

   ulc_ctrl_reg u_ctrlReg
   (
      .clk       (clk),
      .reset     (reset),
      .clearN    (clearN),
      .writeCtrl (writeCtrl),
      .txBus     (txBus),
      .ctrlIf    (ctrlBus.owner)
   );

   assign ctrl = ctrlBus.ctrl;

   // ***************************************************
   // peripheral status capture
   // ***************************************************
   // edge history of the peripheral inputs
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         edgeLast_ff <= 1'b1;
         ctsLast_ff  <= 1'b1;
         holdLast_ff <= 1'b0;
      end
      else
      begin
         edgeLast_ff <= periphEdgeStatusIrq;
         ctsLast_ff  <= ctsN;
         holdLast_ff <= txHoldingEmpty;
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         levelFlag_ff <= 1'b0;
      else
         levelFlag_ff <= clearN && !extLevelStatusN;
   end

   // falling edge flag; set wins over the status read clear
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         edgeFlag_ff <= 1'b0;
      else if (!clearN)
         edgeFlag_ff <= 1'b0;
      else if (edgeLast_ff && !periphEdgeStatusIrq)
         edgeFlag_ff <= 1'b1;
      else if (readStatusStart)
         edgeFlag_ff <= 1'b0;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         ctsFlag_ff <= 1'b0;
      else if (!clearN)
         ctsFlag_ff <= 1'b0;
      else if (ctsLast_ff && !ctsN)
         ctsFlag_ff <= 1'b1;
      else if (readStatusStart)
         ctsFlag_ff <= 1'b0;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         holdFlag_ff <= 1'b0;
      else if (!clearN)
         holdFlag_ff <= 1'b0;
      else if (ctrlBus.reqRise || (txHoldingEmpty && !holdLast_ff))
         holdFlag_ff <= 1'b1;
      else if (writeHolding)
         holdFlag_ff <= 1'b0;
   end

   // ***************************************************
   // status read
   // ***************************************************
   // parity error held low while parity is inhibited
   always_comb
   begin
      statusWord          = BUS_IDLE;
      statusWord[ST_RXRDY]   = rxDataAvailable;
      statusWord[ST_OE]      = rxOverrun;
      statusWord[ST_PARERR]  = rxParityError && !ctrl[BIT_NOPAR];
      statusWord[ST_FE]      = rxFramingError;
      statusWord[ST_LEVEL]   = levelFlag_ff;
      statusWord[ST_EDGE]    = edgeFlag_ff;
      statusWord[ST_SHEMPTY] = txShiftEmpty;
      statusWord[ST_HEMPTY]  = txHoldingEmpty;
   end

   // receive data lives in the receiver; this block answers idle there
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         rxBus_ff   <= BUS_IDLE;
         rxBusOe_ff <= 1'b0;
      end
      else
      begin
         rxBus_ff   <= (chipSelect && readNotWrite && registerSelect) ? statusWord : BUS_IDLE;
         rxBusOe_ff <= chipSelect && readNotWrite;
      end
   end

   // ***************************************************
   // handshake, break and interrupt
   // ***************************************************
   // request to send
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         rtsN_ff <= 1'b1;
      else
         rtsN_ff <= !ctrl[BIT_TXREQ];
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         breakHold_ff <= 1'b0;
      else if (!clearN)
         breakHold_ff <= 1'b0;
      else if (ctrl[BIT_BRK])
         breakHold_ff <= 1'b1;
      else if (ctsN || txWordDone)
         breakHold_ff <= 1'b0;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         serialOut_ff <= 1'b1;
      else if (!clearN)
         serialOut_ff <= 1'b1;
      else
         serialOut_ff <= !(ctrl[BIT_BRK] || breakHold_ff) && txSerialData;
   end

   assign irqPending = (holdFlag_ff && ctrl[BIT_TXREQ]) || rxDataAvailable
                       || (txHoldingEmpty && txShiftEmpty) || ctsFlag_ff || edgeFlag_ff;

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         intN_ff <= 1'b1;
      else
         intN_ff <= !(ctrl[BIT_IRQEN] && irqPending);
   end

   // ***************************************************
   // word format to the shift paths
   // ***************************************************
   // inhibit drops parity slot
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         parityEnable_ff <= 1'b0;
         evenParity_ff   <= 1'b0;
         dataBits_ff     <= DATA_BITS_MIN;
         stopHalves_ff   <= STOP_HALF_1;
      end
      else
      begin
         parityEnable_ff <= !ctrl[BIT_NOPAR];
         evenParity_ff   <= ctrl[BIT_EVEN] && !ctrl[BIT_NOPAR];
         dataBits_ff     <= ulcDataBits(ctrl[BIT_WLS_HI:BIT_WLS_LO]);
         stopHalves_ff   <= ulcStopHalves(ctrl[BIT_WLS_HI:BIT_WLS_LO], ctrl[BIT_STOP]);
      end
   end

   assign rxBus        = rxBus_ff;
   assign rxBusOe      = rxBusOe_ff;
   assign rtsN         = rtsN_ff;
   assign serialOut    = serialOut_ff;
   assign intN         = intN_ff;
   assign parityEnable = parityEnable_ff;
   assign evenParity   = evenParity_ff;
   assign dataBits     = dataBits_ff;
   assign stopHalves   = stopHalves_ff;

   // ***************************************************
   // checks
   // ***************************************************
   property p_rts;
      @(posedge clk) disable iff (reset)
      ctrl[BIT_TXREQ] |=> !rtsN_ff;
   endproperty
   a_rts: assert property (p_rts) else $error("request-to-send not low");

   property p_initHold;
      @(posedge clk) disable iff (reset)
      clearN && ctrlBus.reqRise ##1 clearN && ctrl[BIT_IRQEN] |=> !intN_ff;
   endproperty
   a_initHold: assert property (p_initHold) else $error("no initial holding-empty irq");

   property p_levelLatch;
      @(posedge clk) disable iff (reset)
      clearN |=> levelFlag_ff == !$past(extLevelStatusN);
   endproperty
   a_levelLatch: assert property (p_levelLatch) else $error("level status not latched");

   property p_edgeIrq;
      @(posedge clk) disable iff (reset)
      clearN && edgeLast_ff && !periphEdgeStatusIrq ##1 clearN && ctrl[BIT_IRQEN] |=> !intN_ff;
   endproperty
   a_edgeIrq: assert property (p_edgeIrq) else $error("status edge lost");

   property p_parErrHeld;
      @(posedge clk) disable iff (reset)
      chipSelect && readNotWrite && registerSelect && ctrl[BIT_NOPAR] |=> !rxBus_ff[ST_PARERR];
   endproperty
   a_parErrHeld: assert property (p_parErrHeld) else $error("parity error shown while inhibited");

   property p_noParity;
      @(posedge clk) disable iff (reset)
      ctrl[BIT_NOPAR] |=> !parityEnable_ff && !evenParity_ff;
   endproperty
   a_noParity: assert property (p_noParity) else $error("parity slot while inhibited");

   property p_evenSel;
      @(posedge clk) disable iff (reset)
      !ctrl[BIT_NOPAR] |=> evenParity_ff == $past(ctrl[BIT_EVEN]);
   endproperty
   a_evenSel: assert property (p_evenSel) else $error("parity sense wrong");

   property p_format;
      @(posedge clk) disable iff (reset)
      1'b1 |=> stopHalves_ff == ulcStopHalves($past(ctrl[BIT_WLS_HI:BIT_WLS_LO]), $past(ctrl[BIT_STOP]))
               && dataBits_ff == ulcDataBits($past(ctrl[BIT_WLS_HI:BIT_WLS_LO]));
   endproperty
   a_format: assert property (p_format) else $error("word format decode wrong");

   property p_ieGate;
      @(posedge clk) disable iff (reset)
      !ctrl[BIT_IRQEN] |=> intN_ff;
   endproperty
   a_ieGate: assert property (p_ieGate) else $error("irq while disabled");

   property p_break;
      @(posedge clk) disable iff (reset)
      clearN && ctrl[BIT_BRK] |=> !serialOut_ff;
   endproperty
   a_break: assert property (p_break) else $error("line not held low in break");

   property p_breakHold;
      @(posedge clk) disable iff (reset)
      clearN && breakHold_ff |=> !serialOut_ff;
   endproperty
   a_breakHold: assert property (p_breakHold) else $error("break released early");

   property p_clearLine;
      @(posedge clk) disable iff (reset)
      !clearN |=> serialOut_ff && !breakHold_ff && !edgeFlag_ff;
   endproperty
   a_clearLine: assert property (p_clearLine) else $error("clear did not idle line");

   property p_irqAny;
      @(posedge clk) disable iff (reset)
      ctrl[BIT_IRQEN] && irqPending |=> !intN_ff;
   endproperty
   a_irqAny: assert property (p_irqAny) else $error("pending irq not shown");
endmodule

/* tb/ulc_periph_model.sv */
// ***************************************
// serial peripheral on the far side
// ***************************************
module ulc_periph_model
(
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic rtsN,
   input  wire logic holdCts,
   input  wire logic slow,
   input  wire logic levelActive,
   input  wire logic carrierUp,
   output logic      ctsN,
   output logic      extLevelStatusN,
   output logic      periphEdgeStatusIrq
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [3:0] waitCnt_ff;

   // ready answer
   // slow mode waits eight cycles so a late answer is exercised too
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         waitCnt_ff <= 4'h0;
         ctsN       <= 1'b1;
      end
      else if (rtsN && !holdCts)
      begin
         waitCnt_ff <= 4'h0;
         ctsN       <= 1'b1;
      end
      else if (!slow || waitCnt_ff == 4'h7)
         ctsN <= 1'b0;
      else
         waitCnt_ff <= waitCnt_ff + 4'h1;
   end

   // status lines follow the peripheral state
   always_ff @(posedge clk)
   begin
      extLevelStatusN     <= !levelActive;
      periphEdgeStatusIrq <= carrierUp;
   end
endmodule

/* tb/ulc_line_ctrl_test.sv */
module ulc_line_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   import ulc_pkg::*;

   logic         clk, reset, clearN, chipSelect, registerSelect, readNotWrite;
   logic         busWriteStrobe, txHoldingEmpty, txShiftEmpty, txWordDone, txSerialData;
   logic         rxDataAvailable, rxOverrun, rxParityError, rxFramingError, rxBusOe;
   logic         ctsN, extLevelStatusN, periphEdgeStatusIrq, rtsN, serialOut, intN;
   logic         parityEnable, evenParity, holdCts, slow, levelActive, carrierUp, oeVal;
   ulc_byte_type txBus, rxBus, readVal, code, expStop;
   logic [3:0]   dataBits;
   logic [2:0]   stopHalves;
   int           numErrors, totalChecks;

   ulc_line_ctrl ulc_line_ctrl_i
   (
      .clk, .reset, .clearN, .chipSelect, .registerSelect, .readNotWrite,
      .busWriteStrobe, .txBus, .rxBus, .rxBusOe, .ctsN, .extLevelStatusN,
      .periphEdgeStatusIrq, .txHoldingEmpty, .txShiftEmpty, .txWordDone,
      .txSerialData, .rxDataAvailable, .rxOverrun, .rxParityError, .rxFramingError,
      .rtsN, .serialOut, .intN, .parityEnable, .evenParity, .dataBits, .stopHalves
   );

   ulc_periph_model ulc_periph_model_i
   (
      .clk, .reset, .rtsN, .holdCts, .slow, .levelActive, .carrierUp,
      .ctsN, .extLevelStatusN, .periphEdgeStatusIrq
   );

   // ***************************************
   // helpers
   // ***************************************
   task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      totalChecks++;
      if (seen !== exp)
      begin
         numErrors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task check1(input string what, input logic seen, input logic exp);
      check(what, {7'h0, seen}, {7'h0, exp});
   endtask

   task summarize();
      $display("checks %0d mismatches %0d", totalChecks, numErrors);
      if (numErrors == 0 && totalChecks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // one strobe cycle; select held until the edge after the taking edge
   task bus(input logic cs, input logic sel, input logic rd, input ulc_byte_type data);
      @(posedge clk);
      chipSelect     <= cs;
      registerSelect <= sel;
      readNotWrite   <= rd;
      txBus          <= data;
      busWriteStrobe <= 1'b1;
      @(posedge clk);
      busWriteStrobe <= 1'b0;
      #1 readVal = rxBus;
      oeVal = rxBusOe;
      @(posedge clk);
      chipSelect <= 1'b0;
      #1;
   endtask

   task ctrlWrite(input ulc_byte_type data);
      bus(1'b1, 1'b1, 1'b0, data);
   endtask

   task statusRead();
      bus(1'b1, 1'b1, 1'b1, 8'h00);
   endtask

   // bounded wait; a hang ends the run
   task waitInt(input logic exp);
      int n;
      n = 0;
      while (intN !== exp && n < 8)
      begin
         @(posedge clk);
         #1 n++;
      end
      if (intN !== exp)
      begin
         numErrors++;
         $display("CHECK FAILED intN wait expected %b seen %b", exp, intN);
         summarize();
      end
      check1("intN", intN, exp);
   endtask

   // ***************************************
   // clock and sequence
   // ***************************************
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial
   begin
      reset = 1'b1;
      clearN = 1'b1;
      chipSelect = 1'b0;
      registerSelect = 1'b0;
      readNotWrite = 1'b1;
      busWriteStrobe = 1'b0;
      txBus = 8'h00;
      txHoldingEmpty = 1'b0;
      txShiftEmpty = 1'b0;
      txWordDone = 1'b0;
      txSerialData = 1'b1;
      rxDataAvailable = 1'b0;
      rxOverrun = 1'b0;
      rxParityError = 1'b1;
      rxFramingError = 1'b0;
      holdCts = 1'b0;
      slow = 1'b1;
      levelActive = 1'b0;
      carrierUp = 1'b1;
      numErrors = 0;
      totalChecks = 0;
      repeat (10) @(posedge clk);
      #1;
      check1("rtsN", rtsN, 1'b1); // request idle
      check1("serialOut", serialOut, 1'b1); // line high
      @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      #1;
      check("dataBits", {4'h0, dataBits}, 8'h05); // cleared format
      $display("test reset done");

      // every format code, parity error masking read back each time
      for (int i = 0; i < 32; i++)
      begin
         code = i[7:0];
         expStop = !code[2] ? 8'h02 : (code[4:3] == 2'h0 ? 8'h03 : 8'h04);
         ctrlWrite(code);
         check("dataBits", {4'h0, dataBits}, 8'h05 + {6'h0, code[4:3]}); // length
         check("stopHalves", {5'h0, stopHalves}, expStop); // stop length
         check1("parityEnable", parityEnable, !code[0]); // parity off
         if (!code[0])
            check1("evenParity", evenParity, code[1]); // parity sense
         statusRead();
         check1("statusParErr", readVal[ST_PARERR], !code[0]); // error held low
      end
      $display("test format done");

      // accesses that miss the control register
      bus(1'b0, 1'b1, 1'b0, 8'h00);
      bus(1'b1, 1'b0, 1'b0, 8'h00);
      bus(1'b1, 1'b0, 1'b1, 8'h00);
      check("rxBusData", readVal, 8'h00); // data read empty
      check1("rxBusOe", oeVal, 1'b1); // read drives bus
      check("dataBits", {4'h0, dataBits}, 8'h08); // control kept
      $display("test select done");

      ctrlWrite(8'h27);
      ctrlWrite(8'h98);
      check("stopHalves", {5'h0, stopHalves}, 8'h03); // format kept
      check1("parityEnable", parityEnable, 1'b0); // format kept
      check1("rtsN", rtsN, 1'b0); // request asserted
      waitInt(1'b0); // initial empty interrupt
      repeat (12) @(posedge clk);
      bus(1'b1, 1'b0, 1'b0, 8'h55);
      check1("intN", intN, 1'b0); // clear-to-send pending
      statusRead();
      waitInt(1'b1); // nothing pending
      ctrlWrite(8'h27);
      check1("rtsN", rtsN, 1'b1); // request dropped
      $display("test request done");

      carrierUp <= 1'b0;
      waitInt(1'b0); // edge interrupt
      statusRead();
      check1("statusEdge", readVal[ST_EDGE], 1'b1); // edge status bit
      waitInt(1'b1); // cleared by read
      carrierUp <= 1'b1;
      ctrlWrite(8'h07);
      ctrlWrite(8'h80);
      carrierUp <= 1'b0;
      repeat (12)
      begin
         @(posedge clk);
         #1 check1("intN", intN, 1'b1); // masked
      end
      statusRead();
      check1("statusEdge", readVal[ST_EDGE], 1'b1); // recorded while masked
      ctrlWrite(8'h07);
      $display("test edge status done");

      levelActive <= 1'b1;
      rxDataAvailable <= 1'b1;
      rxOverrun <= 1'b1;
      rxFramingError <= 1'b1;
      txHoldingEmpty <= 1'b1;
      txShiftEmpty <= 1'b1;
      repeat (2) @(posedge clk);
      statusRead();
      check("status", readVal, 8'hdb); // level latched
      levelActive <= 1'b0;
      repeat (2) @(posedge clk);
      statusRead();
      check1("statusLevel", readVal[ST_LEVEL], 1'b0); // level follows
      $display("test level status done");

      // break, then each of the three ways out of the holdover
      slow <= 1'b0;
      for (int w = 0; w < 3; w++)
      begin
         holdCts <= 1'b1;
         ctrlWrite(8'h40);
         check1("serialOut", serialOut, 1'b0); // break low
         ctrlWrite(w == 2 ? 8'h18 : 8'h00);
         check1("serialOut", serialOut, 1'b0); // holdover
         if (w == 0)
            bus(1'b1, 1'b0, 1'b0, 8'h00); // zero word queued; the word-done pulse below restores line
         @(posedge clk);
         txWordDone <= (w == 0);
         holdCts    <= (w != 1);
         clearN     <= (w != 2);
         @(posedge clk);
         txWordDone <= 1'b0;
         clearN     <= 1'b1;
         repeat (3) @(posedge clk);
         #1;
         check1("serialOut", serialOut, 1'b1); // line released
         if (w == 2)
            check("dataBits", {4'h0, dataBits}, 8'h05); // clear resets control
      end
      $display("test break done");
      summarize();
   end
endmodule
